//--- rtl/xbs_pin_mux.sv
// external bus pin mux select: strap latch, select register, pin routing
`timescale 1ns/1ns
`default_nettype none

module xbs_pin_mux
	import xbs_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// straps
	input  wire logic              parallel_strap_pin,
	input  wire logic              serial_strap_pin,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [DATA_W-1:0] rd_data,
	// interrupt
	output logic                   irq,
	// shared pins 0..3
	input  wire logic [PIN_N-1:0]  shared_pin_in,
	output logic      [PIN_N-1:0]  shared_pin_out,
	output logic      [PIN_N-1:0]  shared_pin_oe,
	// serial port c side: tx clock, rx clock, tx sync, rx sync
	input  wire xbs_drv_s [PIN_N-1:0] spc_drv,
	output logic      [PIN_N-1:0]  spc_in,
	// uart side
	input  wire logic              uart_tx,
	output logic                   uart_rx,
	// gp lines three (bit 0) and five (bit 1)
	input  wire xbs_drv_s [1:0]    gp_drv,
	output logic      [1:0]        gp_in,
	// peripheral access checks and clock gating
	input  wire xbs_acc_s          periph_acc,
	output xbs_acc_s               bus_err,
	output xbs_acc_s               clk_en,
	// parallel and host port configuration
	output xbs_par_s               par_cfg
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic xbs_acc_s selected(input logic ph, input logic ser);
		selected.spc  = (ser != SER_MODE_UART);
		selected.uart = (ser == SER_MODE_UART);
		selected.external_memory_interface = (ph == PH_MODE_EXTERNAL_MEMORY_INTERFACE);
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	xbs_state_s st_q;
	xbs_state_s st_d;

	always_comb begin
		logic [EV_W-1:0] ev;
		xbs_acc_s        sel;
		ev  = '0;
		sel = selected(st_q.ph_mode, st_q.ser_mode);
		st_d = st_q;
		st_d.rd_data = '0;

		// access to a deselected peripheral errors when timeout enable is set
		st_d.bus_err.spc  = periph_acc.spc && !sel.spc && st_q.to_en;
		st_d.bus_err.uart = periph_acc.uart && !sel.uart && st_q.to_en;
		st_d.bus_err.external_memory_interface = periph_acc.external_memory_interface && !sel.external_memory_interface && st_q.to_en;
		ev[EV_ERR_SPC]  = st_d.bus_err.spc;
		ev[EV_ERR_UART] = st_d.bus_err.uart;
		ev[EV_ERR_EXTERNAL_MEMORY_INTERFACE] = st_d.bus_err.external_memory_interface;

		// clocks follow selection
		st_d.clk_en = sel;

		// parallel and host port configuration
		st_d.par.external_memory_interface_sel      = (st_q.ph_mode == PH_MODE_EXTERNAL_MEMORY_INTERFACE);
		st_d.par.host_muxed8   = (st_q.ph_mode == PH_MODE_EXTERNAL_MEMORY_INTERFACE);
		st_d.par.host_nonmux16 = (st_q.ph_mode != PH_MODE_EXTERNAL_MEMORY_INTERFACE);
		st_d.par.par_gp_io_en  = (st_q.ph_mode != PH_MODE_EXTERNAL_MEMORY_INTERFACE);
		st_d.par.host_gp_io_en = (st_q.ph_mode != PH_MODE_EXTERNAL_MEMORY_INTERFACE);

		// serial mux routing; serial port c, or the uart and gp lines, cross this mux, the first and
		// second serial ports keep their own pins and never reach this block
		if (st_q.ser_mode == SER_MODE_UART) begin
			st_d.pin_o[0]  = gp_drv[0].o;
			st_d.pin_oe[0] = gp_drv[0].oe;
			st_d.pin_o[1]  = 1'h0;
			st_d.pin_oe[1] = 1'h0;
			st_d.pin_o[2]  = gp_drv[1].o;
			st_d.pin_oe[2] = gp_drv[1].oe;
			st_d.pin_o[3]  = uart_tx;
			st_d.pin_oe[3] = 1'h1;
			st_d.uart_rx   = shared_pin_in[1];
			st_d.gp_in[0]  = shared_pin_in[0];
			st_d.gp_in[1]  = shared_pin_in[2];
			st_d.spc_in    = '0;
		end else begin
			for (int i = 0; i < PIN_N; i++) begin
				st_d.pin_o[i]  = spc_drv[i].o;
				st_d.pin_oe[i] = spc_drv[i].oe;
			end
			st_d.spc_in  = shared_pin_in;
			st_d.uart_rx = UART_IDLE;
			st_d.gp_in   = '0;
		end

		// register writes
		if (wr_stb) begin
			if (hit(addr, BUS_SELECT_ADDR)) begin
				st_d.rsvd_rw = wr_data[RSVD_RW_BIT];
				// mode bits hold the strapped value; a change attempt is flagged
				ev[EV_MODE_WR] = (wr_data[PH_MODE_BIT] != st_q.ph_mode)
					|| (wr_data[SER_MODE_BIT] != st_q.ser_mode);
			end
			if (hit(addr, IRQ_MASK_ADDR)) begin
				st_d.irq_mask = wr_data[EV_W-1:0];
			end
			if (hit(addr, TIMEOUT_ADDR)) begin
				st_d.to_en = wr_data[TO_EN_BIT];
			end
		end

		// sticky status: write one clears, a new event wins
		st_d.irq_stat = st_q.irq_stat;
		if (wr_stb && hit(addr, IRQ_STAT_ADDR)) begin
			st_d.irq_stat = st_q.irq_stat & ~wr_data[EV_W-1:0];
		end
		st_d.irq_stat = st_d.irq_stat | ev;
		st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

		// register reads, data in the next cycle
		if (rd_stb) begin
			if (hit(addr, BUS_SELECT_ADDR)) begin
				st_d.rd_data[PH_MODE_BIT]  = st_q.ph_mode;
				st_d.rd_data[SER_MODE_BIT] = st_q.ser_mode;
				st_d.rd_data[RSVD_RW_BIT]  = st_q.rsvd_rw;
			end
			if (hit(addr, IRQ_STAT_ADDR)) begin
				st_d.rd_data[EV_W-1:0] = st_q.irq_stat;
			end
			if (hit(addr, IRQ_MASK_ADDR)) begin
				st_d.rd_data[EV_W-1:0] = st_q.irq_mask;
			end
			if (hit(addr, TIMEOUT_ADDR)) begin
				st_d.rd_data[TO_EN_BIT] = st_q.to_en;
			end
		end

		// synchronous reset: straps sampled every reset cycle, then frozen
		if (!rst_b) begin
			st_d          = '0;
			st_d.ph_mode  = parallel_strap_pin;
			st_d.ser_mode = serial_strap_pin;
			st_d.rsvd_rw  = RST_RSVD_RW;
			st_d.to_en    = RST_TO_EN;
			st_d.irq_stat = RST_EVENTS;
			st_d.irq_mask = RST_EVENTS;
			st_d.uart_rx  = UART_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		st_q <= st_d;
	end

	// ------------------------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------------------------
	assign rd_data        = st_q.rd_data;
	assign irq            = st_q.irq;
	assign shared_pin_out = st_q.pin_o;
	assign shared_pin_oe  = st_q.pin_oe;
	assign spc_in         = st_q.spc_in;
	assign uart_rx        = st_q.uart_rx;
	assign gp_in          = st_q.gp_in;
	assign bus_err        = st_q.bus_err;
	assign clk_en         = st_q.clk_en;
	assign par_cfg        = st_q.par;

endmodule

`default_nettype wire

//--- rtl/xbs_pkg.sv
// constants, types and state layout of the external bus pin mux select block
// How it works
// - at reset the serial strap level loads serial mode bit 2; high selects serial port c
// - mode 0 puts uart receive on shared pin 1, uart transmit on shared pin 3
// - mode 0 puts gp line three on shared pin 0, gp line five on pin 2
// - mode 0 disables serial port c; its accesses error when timeout enable is 1
// - mode 1 routes tx clock, rx clock, tx sync, rx sync to pins 0..3
// - mode 1 disables the uart; its accesses error when timeout enable is 1
// - mode 1 offers gp lines three and five on no pin
// - parallel strap high gives 32-bit memory interface and 8-bit muxed host port
// - parallel strap low gives 16-bit host plus parallel gp io, host pins gp io
// - bit 0 reads back the strapped parallel and host mode
// - bit 2 reads back the strapped serial mode
// - clocks of serial port c, uart and memory interface stop when unselected
// - access to a deselected module errors when timeout enable is set
// - select register is 16 bits at 0x6c00; bits 15-4 and 1 read zero
// - first and second serial ports bypass this mux entirely
package xbs_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 16;
	localparam logic [15:0] BUS_SELECT_ADDR = 16'h6c00;
	localparam logic [15:0] IRQ_STAT_ADDR   = 16'h6c10;
	localparam logic [15:0] IRQ_MASK_ADDR   = 16'h6c12;
	localparam logic [15:0] TIMEOUT_ADDR    = 16'h6c14;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int PH_MODE_BIT  = 0;
	localparam int SER_MODE_BIT = 2;
	localparam int RSVD_RW_BIT  = 3;
	localparam int TO_EN_BIT    = 0;
	localparam int EV_W         = 4;
	localparam int EV_ERR_SPC   = 0;
	localparam int EV_ERR_UART  = 1;
	localparam int EV_ERR_EXTERNAL_MEMORY_INTERFACE  = 2;
	localparam int EV_MODE_WR   = 3;

	// ------------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------------
	localparam logic              RST_RSVD_RW  = 1'h0;
	localparam logic              RST_TO_EN    = 1'h0;
	localparam logic [EV_W-1:0]   RST_EVENTS   = 4'h0;
	localparam logic              SER_MODE_UART = 1'h0;
	localparam logic              PH_MODE_EXTERNAL_MEMORY_INTERFACE = 1'h1;
	localparam logic              UART_IDLE    = 1'h1;
	localparam int                PIN_N        = 4;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic o;
		logic oe;
	} xbs_drv_s;

	// one bit per gated peripheral
	typedef struct packed {
		logic external_memory_interface;
		logic uart;
		logic spc;
	} xbs_acc_s;

	typedef struct packed {
		logic external_memory_interface_sel;
		logic host_muxed8;
		logic host_nonmux16;
		logic par_gp_io_en;
		logic host_gp_io_en;
	} xbs_par_s;

	typedef struct packed {
		logic              ph_mode;
		logic              ser_mode;
		logic              rsvd_rw;
		logic              to_en;
		logic [EV_W-1:0]   irq_stat;
		logic [EV_W-1:0]   irq_mask;
		logic              irq;
		logic [DATA_W-1:0] rd_data;
		logic [PIN_N-1:0]  pin_o;
		logic [PIN_N-1:0]  pin_oe;
		logic [PIN_N-1:0]  spc_in;
		logic [1:0]        gp_in;
		logic              uart_rx;
		xbs_acc_s          clk_en;
		xbs_acc_s          bus_err;
		xbs_par_s          par;
	} xbs_state_s;

endpackage

//--- tb/external_bus_pin_mux_select_bench.sv
// self-checking bench for the pin mux select block
`timescale 1ns/1ns
`default_nettype none
module external_bus_pin_mux_select_bench
	import xbs_pkg::*;
;
	logic           clock = 1'b0, rst_b = 1'b0, par_s = 1'b0, ser_s = 1'b0;
	logic           wr_stb = 1'b0, rd_stb = 1'b0, uart_tx, irq, uart_rx;
	logic [15:0]    addr = 16'h0, wr_data = 16'h0, rd_data;
	logic [3:0]     pin_in, pin_out, pin_oe, pin_ext, spc_in;
	logic [1:0]     gp_in;
	xbs_drv_s [3:0] spc_drv;
	xbs_drv_s [1:0] gp_drv;
	xbs_acc_s       acc = 3'h0, bus_err, clk_en;
	xbs_par_s       par_cfg;
	int             failures = 0, total_checks = 0;
	assign pin_in = (pin_out & pin_oe) | (pin_ext & ~pin_oe);
	xbs_periph_model far (.clock(clock), .spc_drv(spc_drv), .gp_drv(gp_drv),
		.uart_tx(uart_tx), .pin_ext(pin_ext));
	xbs_pin_mux dut (.clock(clock), .rst_b(rst_b), .parallel_strap_pin(par_s),
		.serial_strap_pin(ser_s), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .shared_pin_in(pin_in),
		.shared_pin_out(pin_out), .shared_pin_oe(pin_oe), .spc_drv(spc_drv),
		.spc_in(spc_in), .uart_tx(uart_tx), .uart_rx(uart_rx), .gp_drv(gp_drv),
		.gp_in(gp_in), .periph_acc(acc), .bus_err(bus_err), .clk_en(clk_en),
		.par_cfg(par_cfg));
	initial begin
		forever #50 clock = ~clock;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		{addr, wr_data, wr_stb} <= {a, d, 1'b1};
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock);
		{addr, rd_stb} <= {a, 1'b1};
		@(posedge clock);
		rd_stb <= 1'b0;
		@(negedge clock);
		chk(rd_data, exp);
	endtask
	task acc_t(input xbs_acc_s a, input xbs_acc_s exp);
		@(posedge clock);
		acc <= a;
		@(posedge clock);
		acc <= 3'h0;
		@(negedge clock);
		chk(16'(bus_err), 16'(exp));
	endtask
	// straps move right after release; the latched modes must not
	task reset_to(input logic p, input logic s);
		@(posedge clock);
		{rst_b, par_s, ser_s} <= {1'b0, p, s};
		repeat (16) @(posedge clock);
		{rst_b, par_s, ser_s} <= {1'b1, ~p, ~s};
		repeat (2) @(posedge clock);
	endtask
	task t_strap(input logic p, input logic s);
		rd(BUS_SELECT_ADDR, {13'h0, s, 1'b0, p});
		chk(16'(clk_en), {13'h0, p, ~s, s});
		chk(16'(par_cfg), {11'h0, p, p, ~p, ~p, ~p});
		rd(16'h6c02, 16'h0);
		$display("strap test done");
	endtask
	task t_mode_wr(input logic p, input logic s);
		wr(IRQ_MASK_ADDR, 16'h0008);
		wr(BUS_SELECT_ADDR, {13'h0, ~s, 1'b0, ~p});
		rd(BUS_SELECT_ADDR, {13'h0, s, 1'b0, p});
		chk(16'(irq), 16'h1);
		rd(IRQ_STAT_ADDR, 16'h0008);
		wr(IRQ_STAT_ADDR, 16'h0008);
		rd(IRQ_STAT_ADDR, 16'h0);
		chk(16'(irq), 16'h0);
		$display("mode write test done");
	endtask
	task t_err(input logic p, input logic s);
		wr(TIMEOUT_ADDR, 16'h0);
		acc_t(3'b111, 3'h0);
		wr(TIMEOUT_ADDR, 16'h1);
		acc_t(3'b111, {~p, s, ~s});
		rd(IRQ_STAT_ADDR, {13'h0, ~p, s, ~s});
		wr(IRQ_MASK_ADDR, 16'h0007);
		rd(TIMEOUT_ADDR, 16'h1);
		chk(16'(irq), 16'h1);
		wr(IRQ_MASK_ADDR, 16'h0);
		rd(IRQ_MASK_ADDR, 16'h0);
		chk(16'(irq), 16'h0);
		wr(IRQ_STAT_ADDR, 16'h000f);
		rd(IRQ_STAT_ADDR, 16'h0);
		$display("bus error test done");
	endtask
	task finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		$display("mismatch at %0t: run limit reached", $time);
		finish_test;
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			reset_to(i[0], i[1]);
			t_strap(i[0], i[1]);
			t_mode_wr(i[0], i[1]);
			t_err(i[0], i[1]);
		end
		finish_test;
	end
endmodule
`default_nettype wire

//--- tb/xbs_checker.sv
// assertions for the pin mux select block
`timescale 1ns/1ns
`default_nettype none
module xbs_checker
	import xbs_pkg::*;
(
	// clock, reset, register port
	input wire logic           clock,
	input wire logic           rst_b,
	input wire logic           rd_stb,
	input wire logic [15:0]    addr,
	input wire logic [15:0]    rd_data,
	// pins and peripheral sides
	input wire logic [3:0]     shared_pin_in,
	input wire logic [3:0]     shared_pin_out,
	input wire logic [3:0]     shared_pin_oe,
	input wire xbs_drv_s [3:0] spc_drv,
	input wire logic [3:0]     spc_in,
	input wire logic           uart_tx,
	input wire logic           uart_rx,
	input wire xbs_drv_s [1:0] gp_drv,
	input wire logic [1:0]     gp_in,
	// access, gating, configuration
	input wire xbs_acc_s       periph_acc,
	input wire xbs_acc_s       bus_err,
	input wire xbs_acc_s       clk_en,
	input wire xbs_par_s       par_cfg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	chk_uart_pins: assert property ($past(rst_b) && !clk_en.spc |->
		shared_pin_out[3] == $past(uart_tx) && shared_pin_oe[3] && !shared_pin_oe[1]
		&& uart_rx == $past(shared_pin_in[1])) else $error("uart pin routing wrong");
	chk_gp_pins: assert property ($past(rst_b) && !clk_en.spc |-> spc_in == 4'h0 &&
		{shared_pin_out[2], shared_pin_out[0], shared_pin_oe[2], shared_pin_oe[0]}
		== $past({gp_drv[1].o, gp_drv[0].o, gp_drv[1].oe, gp_drv[0].oe}))
		else $error("gp pin routing wrong");
	chk_spc_pins: assert property ($past(rst_b) && clk_en.spc |->
		shared_pin_out == $past({spc_drv[3].o, spc_drv[2].o, spc_drv[1].o, spc_drv[0].o})
		&& shared_pin_oe == $past({spc_drv[3].oe, spc_drv[2].oe, spc_drv[1].oe,
		spc_drv[0].oe}) && spc_in == $past(shared_pin_in)) else $error("spc routing wrong");
	chk_gp_gone: assert property ($past(rst_b) && clk_en.spc |->
		gp_in == 2'h0 && uart_rx) else $error("gp or uart active in mode 1");
	chk_err_cause: assert property (bus_err != 3'h0 |-> (bus_err & clk_en) == 3'h0
		&& ($past(periph_acc) & bus_err) == bus_err) else $error("bus error without cause");
	chk_clk_excl: assert property ($past(rst_b) |-> clk_en.spc != clk_en.uart)
		else $error("serial clocks not exclusive");
	chk_par_cfg: assert property ($past(rst_b) |-> par_cfg ==
		{clk_en.external_memory_interface, clk_en.external_memory_interface, {3{!clk_en.external_memory_interface}}}) else $error("parallel config wrong");
	chk_modes_hold: assert property ($past(rst_b) && $past(rst_b, 2) |->
		$stable(clk_en) && $stable(par_cfg)) else $error("modes moved after reset");
	chk_sel_read: assert property ($past(rd_stb) && $past(addr) == BUS_SELECT_ADDR |->
		rd_data[15:4] == 12'h0 && !rd_data[1] && rd_data[2] == clk_en.spc
		&& rd_data[0] == clk_en.external_memory_interface) else $error("select readback wrong");
	cov_spc_err: cover property (bus_err.spc);
	cov_uart_err: cover property (bus_err.uart);
	cov_external_memory_interface_err: cover property (bus_err.external_memory_interface);
endmodule
bind xbs_pin_mux xbs_checker chk (.*);
`default_nettype wire

//--- tb/xbs_periph_model.sv
// far-side model: serial port c, uart and gp line drivers, far pin levels
`timescale 1ns/1ns
`default_nettype none
module xbs_periph_model
	import xbs_pkg::*;
(
	// clock
	input  wire logic          clock,
	// drives toward the mux and far pin levels
	output var xbs_drv_s [3:0] spc_drv,
	output var xbs_drv_s [1:0] gp_drv,
	output logic               uart_tx,
	output logic [3:0]         pin_ext
);
	logic [11:0] cnt_q = 12'h0;
	// pattern changes every cycle so a stale level never passes for routing
	always @(posedge clock) cnt_q <= cnt_q + 12'h9d5;
	assign {spc_drv, gp_drv} = cnt_q;
	assign uart_tx = cnt_q[3] ^ cnt_q[0];
	assign pin_ext = ~cnt_q[7:4];
endmodule
`default_nettype wire
